// ==== inc/apath_map.svh ====
// register offsets, field positions, reset values and timing counts
// assumes the includer works in 100 MHz clock cycles and audio samples
`ifndef APATH_MAP_SVH
`define APATH_MAP_SVH

`define SAMPLE_W           24
`define REG_ROUTE_ADDR     8'h2A
`define REG_PROG_ADDR      8'h2B
`define REG_MISS_ADDR      8'h2C
`define REG_AMUTE_ADDR     8'h3B
`define REG_VLINK_ADDR     8'h3C
`define REG_LEFT_VOLUME_CODE_ADDR      8'h3D
`define REG_RIGHT_VOLUME_CODE_ADDR      8'h3E

`define ROUTE_RESET        8'h11
`define PROG_RESET         8'h01
`define MISS_RESET         8'h00
`define AMUTE_RESET        8'h00
`define VLINK_RESET        8'h00
`define VOL_RESET          8'h30
`define MISS_READ_MASK     8'h07

`define PATH_ZERO          2'h0
`define PATH_OWN           2'h1
`define PATH_OTHER         2'h2
`define PROG_ROM1          5'h01
`define VLINK_FOLLOW       2'h1
`define VOL_MUTE           8'hFF

`define CLK_RATE_HZ        100000000
`define MISS_UNIT_S        1
`define MISS_UNIT_CYCLES   (`MISS_UNIT_S * `CLK_RATE_HZ)

// zero-run lengths in microseconds at the reference rate, turned into samples
`define AM_RATE_KHZ        96
`define AM_T0_US           11500
`define AM_T1_US           53000
`define AM_T2_US           106500
`define AM_T3_US           266500
`define AM_T4_US           535000
`define AM_T5_US           1065000
`define AM_T6_US           2665000
`define AM_T7_US           5330000
`define AM_SAMPLES(t)      (((t) * `AM_RATE_KHZ) / 1000)

`endif

// ==== inc/apath_pkg.sv ====
// types shared by the audio path configuration block
// assumes apath_map.svh is included ahead of it
`include "apath_map.svh"

package apath_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [`SAMPLE_W-1:0] left;
        logic [`SAMPLE_W-1:0] right;
    } stereo_t;

    typedef enum logic [1:0] {
        CLK_RUNNING,
        CLK_WAITING,
        CLK_MISSING
    } clk_mon_state_t;

endpackage

// ==== logic/zero_mute_timer.sv ====
// run-length counter of zero samples for one DAC channel
// assumes sample_valid_in is a one-cycle strobe per sample
`timescale 1ns/100ps
`include "apath_map.svh"

module zero_mute_timer (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       sample_valid_in,
    input  wire logic       sample_zero_in,
    input  wire logic [2:0] length_code_in,
    output logic            muted_out
);

    logic [19:0] run_count;
    logic [19:0] next_run_count;
    logic        next_muted;
    logic [19:0] limit;

    // lengths are sample counts, so real time scales with the sample rate
    function automatic logic [19:0] run_limit(input logic [2:0] code);
        case (code)
            3'h0:    run_limit = 20'(`AM_SAMPLES(`AM_T0_US));
            3'h1:    run_limit = 20'(`AM_SAMPLES(`AM_T1_US));
            3'h2:    run_limit = 20'(`AM_SAMPLES(`AM_T2_US));
            3'h3:    run_limit = 20'(`AM_SAMPLES(`AM_T3_US));
            3'h4:    run_limit = 20'(`AM_SAMPLES(`AM_T4_US));
            3'h5:    run_limit = 20'(`AM_SAMPLES(`AM_T5_US));
            3'h6:    run_limit = 20'(`AM_SAMPLES(`AM_T6_US));
            default: run_limit = 20'(`AM_SAMPLES(`AM_T7_US));
        endcase
    endfunction

    assign limit = run_limit(length_code_in);

    always_comb begin
        next_run_count = run_count;
        next_muted     = muted_out;
        if (sample_valid_in) begin
            if (sample_zero_in) begin
                // saturate so a shortened length takes effect at once
                next_run_count = (run_count >= limit) ? limit : run_count + 20'h00001;
                next_muted     = (next_run_count >= limit);
            end else begin
                next_run_count = 20'h00000;
                next_muted     = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_count <= 20'h00000;
            muted_out <= 1'b0;
        end else begin
            run_count <= next_run_count;
            muted_out <= next_muted;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence nonzero_sample;
        sample_valid_in && !sample_zero_in;
    endsequence

    a_nonzero_release: assert property (nonzero_sample |=> !muted_out && run_count == 20'h00000)
        else $error("zero mute not released by nonzero sample");
    a_mute_needs_run: assert property ($rose(muted_out) |-> $past(run_count) + 20'h00001 >= $past(limit))
        else $error("zero mute set before run length reached");
    a_shortest_length: assert property (length_code_in == 3'h0 |-> limit == 20'h00450)
        else $error("shortest zero run is not 1104 samples");

endmodule

// ==== logic/audio_path_automute_config.sv ====
// register bank and data path for DAC routing, program select, clock-loss power-down and zero auto-mute
// assumes a control-port front end that hands over single byte reads and writes,
// and serial audio already deserialised into one stereo word per sample strobe
`timescale 1ns/100ps
`include "apath_map.svh"

// Functional notes
// - left DAC takes zero, left input or right input from its two-bit selector
// - right DAC takes zero, right input or left input from its two-bit selector
// - five-bit program selector chooses processing program, code 00001 is first ROM program
// - both audio clocks low for the set period declare clocks missing, DAC powers down unless ignore_missing_clock_in is set
// - left auto-mute only after programmed count of consecutive zero samples
// - right auto-mute uses its own independent zero-run length code
// - auto-mute lengths are fixed sample counts referenced to 96 kHz
// - volume link 00 keeps volumes independent, 01 makes right follow left
// - volume code steps 0.5 dB from +24 dB, all ones means mute
// - clocks held high never count as missing
module audio_path_automute_config #(
    parameter int unsigned MISS_UNIT_CYCLES = `MISS_UNIT_CYCLES
) (
    input  wire logic                  mclk_in,
    input  wire logic                  arst_n_in,
    input  wire apath_pkg::reg_req_t   reg_req_in,
    output logic [7:0]                 reg_rdata_out,
    input  wire logic                  bclk_in,
    input  wire logic                  fclk_in,
    input  wire logic                  ignore_missing_clock_in,
    input  wire logic                  sample_valid_in,
    input  wire apath_pkg::stereo_t    sample_in,
    output apath_pkg::stereo_t         dac_out,
    output logic                       dac_valid_out,
    output logic                       left_muted_out,
    output logic                       right_muted_out,
    output logic                       clock_missing_out,
    output logic                       dac_powerdown_out,
    output logic [4:0]                 program_out,
    output logic                       program_rom1_out,
    output logic [7:0]                 left_volume_out,
    output logic [7:0]                 right_volume_out
);

    logic                      rst_sync1;
    logic                      rst_n;
    logic [7:0]                route, prog, miss, amute, vlink, left_volume_code, right_volume_code;
    logic [7:0]                next_route, next_prog, next_miss, next_amute, next_vlink, next_left_volume_code, next_right_volume_code;
    logic [7:0]                next_rdata;
    apath_pkg::clk_mon_state_t state, next_state;
    logic [29:0]               unit_div, next_unit_div;
    logic [3:0]                units, next_units;
    logic                      both_low;
    logic                      unit_tick;
    logic                      next_powerdown;
    apath_pkg::stereo_t        routed, next_dac;
    logic                      next_dac_valid;

    // reset is released through two stages so every flop leaves reset on the same edge
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync1 <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n     <= rst_sync1;
        end
    end

    function automatic logic [`SAMPLE_W-1:0] path_pick(input logic [1:0] sel,
                                                       input logic [`SAMPLE_W-1:0] own,
                                                       input logic [`SAMPLE_W-1:0] other);
        case (sel)
            `PATH_OWN:   path_pick = own;
            `PATH_OTHER: path_pick = other;
            // the reserved code is forced to silence rather than left undefined
            default:     path_pick = '0;
        endcase
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        case (addr)
            `REG_ROUTE_ADDR: reg_read = route;
            `REG_PROG_ADDR:  reg_read = prog;
            `REG_MISS_ADDR:  reg_read = miss & `MISS_READ_MASK;
            `REG_AMUTE_ADDR: reg_read = amute;
            `REG_VLINK_ADDR: reg_read = vlink;
            `REG_LEFT_VOLUME_CODE_ADDR:  reg_read = left_volume_code;
            `REG_RIGHT_VOLUME_CODE_ADDR:  reg_read = right_volume_code;
            default:         reg_read = 8'h00;
        endcase
    endfunction

    always_comb begin
        next_route = route;
        next_prog  = prog;
        next_miss  = miss;
        next_amute = amute;
        next_vlink = vlink;
        next_left_volume_code  = left_volume_code;
        next_right_volume_code  = right_volume_code;
        next_rdata = reg_rdata_out;
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                `REG_ROUTE_ADDR: next_route = reg_req_in.wdata;
                `REG_PROG_ADDR:  next_prog  = reg_req_in.wdata;
                `REG_MISS_ADDR:  next_miss  = reg_req_in.wdata & `MISS_READ_MASK;
                `REG_AMUTE_ADDR: next_amute = reg_req_in.wdata;
                `REG_VLINK_ADDR: next_vlink = reg_req_in.wdata;
                `REG_LEFT_VOLUME_CODE_ADDR:  next_left_volume_code  = reg_req_in.wdata;
                `REG_RIGHT_VOLUME_CODE_ADDR:  next_right_volume_code  = reg_req_in.wdata;
                default: ;
            endcase
        end
        if (reg_req_in.rd) begin
            next_rdata = reg_read(reg_req_in.addr);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            route         <= `ROUTE_RESET;
            prog          <= `PROG_RESET;
            miss          <= `MISS_RESET;
            amute         <= `AMUTE_RESET;
            vlink         <= `VLINK_RESET;
            left_volume_code          <= `VOL_RESET;
            right_volume_code          <= `VOL_RESET;
            reg_rdata_out <= 8'h00;
        end else begin
            route         <= next_route;
            prog          <= next_prog;
            miss          <= next_miss;
            amute         <= next_amute;
            vlink         <= next_vlink;
            left_volume_code          <= next_left_volume_code;
            right_volume_code          <= next_right_volume_code;
            reg_rdata_out <= next_rdata;
        end
    end

    assign program_out      = prog[4:0];
    assign program_rom1_out = (prog[4:0] == `PROG_ROM1);
    assign left_volume_out  = left_volume_code;
    // link codes other than follow behave as independent
    assign right_volume_out = (vlink[1:0] == `VLINK_FOLLOW) ? left_volume_code : right_volume_code;

    // a clock parked high keeps both_low false, so it never starts the timeout
    assign both_low  = !bclk_in && !fclk_in;
    assign unit_tick = (unit_div == 30'(MISS_UNIT_CYCLES - 1));

    always_comb begin
        next_state    = state;
        next_unit_div = unit_div;
        next_units    = units;
        case (state)
            apath_pkg::CLK_RUNNING: begin
                next_unit_div = 30'h00000000;
                next_units    = 4'h0;
                if (both_low) begin
                    next_state = apath_pkg::CLK_WAITING;
                end
            end
            apath_pkg::CLK_WAITING: begin
                if (!both_low) begin
                    // any cycle with a clock high starts the wait over
                    next_state    = apath_pkg::CLK_RUNNING;
                    next_unit_div = 30'h00000000;
                    next_units    = 4'h0;
                end else if (unit_tick) begin
                    next_unit_div = 30'h00000000;
                    next_units    = units + 4'h1;
                    // at-or-past, so a period shortened mid-wait still ends the wait
                    if (units + 4'h1 >= {1'b0, miss[2:0]} + 4'h1) begin
                        next_state = apath_pkg::CLK_MISSING;
                    end
                end else begin
                    next_unit_div = unit_div + 30'h00000001;
                end
            end
            apath_pkg::CLK_MISSING: begin
                if (!both_low) begin
                    next_state    = apath_pkg::CLK_RUNNING;
                    next_unit_div = 30'h00000000;
                    next_units    = 4'h0;
                end
            end
            default: next_state = apath_pkg::CLK_RUNNING;
        endcase
        next_powerdown = (next_state == apath_pkg::CLK_MISSING) && !ignore_missing_clock_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state             <= apath_pkg::CLK_RUNNING;
            unit_div          <= 30'h00000000;
            units             <= 4'h0;
            dac_powerdown_out <= 1'b0;
        end else begin
            state             <= next_state;
            unit_div          <= next_unit_div;
            units             <= next_units;
            dac_powerdown_out <= next_powerdown;
        end
    end

    assign clock_missing_out = (state == apath_pkg::CLK_MISSING);

    always_comb begin
        routed.left    = path_pick(route[5:4], sample_in.left, sample_in.right);
        routed.right   = path_pick(route[1:0], sample_in.right, sample_in.left);
        next_dac       = dac_out;
        next_dac_valid = sample_valid_in;
        if (sample_valid_in) begin
            next_dac = routed;
            if (dac_powerdown_out || left_volume_out == `VOL_MUTE) begin
                next_dac.left = '0;
            end
            if (dac_powerdown_out || right_volume_out == `VOL_MUTE) begin
                next_dac.right = '0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            dac_out       <= '0;
            dac_valid_out <= 1'b0;
        end else begin
            dac_out       <= next_dac;
            dac_valid_out <= next_dac_valid;
        end
    end

    // zero runs are judged on each DAC channel's routed sample, before volume mute and power-down zero it
    zero_mute_timer u_left_mute (
        .clk_in          (mclk_in),
        .rst_n_in        (rst_n),
        .sample_valid_in (sample_valid_in),
        .sample_zero_in  (routed.left == '0),
        .length_code_in  (amute[6:4]),
        .muted_out       (left_muted_out)
    );

    zero_mute_timer u_right_mute (
        .clk_in          (mclk_in),
        .rst_n_in        (rst_n),
        .sample_valid_in (sample_valid_in),
        .sample_zero_in  (routed.right == '0),
        .length_code_in  (amute[2:0]),
        .muted_out       (right_muted_out)
    );

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    sequence left_sample_routed_zero;
        sample_valid_in && route[5:4] == `PATH_ZERO;
    endsequence

    sequence right_takes_left;
        sample_valid_in && route[1:0] == `PATH_OTHER && !dac_powerdown_out && right_volume_out != `VOL_MUTE;
    endsequence

    a_left_path_mute: assert property (left_sample_routed_zero |=> dac_out.left == '0)
        else $error("left DAC not silent on zero path");
    a_right_path_cross: assert property (right_takes_left |=> dac_out.right == $past(sample_in.left))
        else $error("right DAC not fed from left input");
    a_prog_write_rom1: assert property (reg_req_in.wr && reg_req_in.addr == `REG_PROG_ADDR
                                        && reg_req_in.wdata[4:0] == `PROG_ROM1 |=> program_rom1_out)
        else $error("program select write not applied");
    a_powerdown_cause: assert property (dac_powerdown_out |-> clock_missing_out && $past(both_low))
        else $error("power-down without missing clocks");
    a_units_bound: assert property (units <= {1'b0, miss[2:0]} + 4'h1)
        else $error("missing-clock unit count past period");
    a_high_no_miss: assert property (!both_low |=> !clock_missing_out && units == 4'h0)
        else $error("high clock counted as missing");
    a_volume_follow: assert property (vlink[1:0] == `VLINK_FOLLOW |-> right_volume_out == left_volume_code)
        else $error("right volume not following left");
    a_volume_mute: assert property (sample_valid_in && left_volume_out == `VOL_MUTE |=> dac_out.left == '0)
        else $error("left mute code not silencing DAC");

endmodule

// ==== verif/audio_source.sv ====
// model of the serial audio source: audio clock levels and deserialised stereo samples
// assumes the bench calls stream() from its main sequence; every output moves on a falling edge
`timescale 1ns/100ps
`include "apath_map.svh"

module audio_source (
    input  wire logic          mclk_in,
    input  wire logic [1:0]    clk_mode_in,
    output logic               bclk_out,
    output logic               fclk_out,
    output logic               valid_out,
    output apath_pkg::stereo_t sample_out
);
    initial begin
        bclk_out = 1'b0;
        fclk_out = 1'b1;
        valid_out = 1'b0;
        sample_out = '0;
    end

    // mode 0 runs both clocks in opposite phase so they are never low together,
    // mode 1 parks both low, mode 2 parks both high
    always @(negedge mclk_in) begin
        case (clk_mode_in)
            2'h1: begin
                bclk_out <= 1'b0;
                fclk_out <= 1'b0;
            end
            2'h2: begin
                bclk_out <= 1'b1;
                fclk_out <= 1'b1;
            end
            default: begin
                bclk_out <= ~bclk_out;
                fclk_out <= bclk_out;
            end
        endcase
    end

    // n back-to-back samples; data is inverted once the strobe drops so stale words never look valid
    task automatic stream(input logic [`SAMPLE_W-1:0] l, input logic [`SAMPLE_W-1:0] r, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_in);
            valid_out = 1'b1;
            sample_out = '{left: l, right: r};
        end
        @(negedge mclk_in);
        valid_out = 1'b0;
        sample_out = ~sample_out;
    endtask
endmodule

// ==== verif/audio_path_automute_config_test.sv ====
// self-checking bench for the audio path configuration block
// assumes the design's reset synchroniser and a shortened missing-clock unit of UNIT cycles
`timescale 1ns/100ps
`include "apath_map.svh"

module audio_path_automute_config_test;
    localparam int unsigned UNIT = 20;
    logic               mclk_in;
    logic               arst_n_in;
    logic               ignore;
    logic [1:0]         clk_mode;
    logic [7:0]         rdata;
    logic [7:0]         lvol;
    logic [7:0]         rvol;
    logic [4:0]         prog;
    logic               bclk, fclk, svalid, dvalid, lmute, rmute, miss, pdown, rom1;
    apath_pkg::reg_req_t req;
    apath_pkg::stereo_t sample;
    apath_pkg::stereo_t dac;
    int                 bad_count;
    int                 checks_done;
    logic [7:0]         addrs [7] = '{8'h2A, 8'h2B, 8'h2C, 8'h3B, 8'h3C, 8'h3D, 8'h3E};
    logic [7:0]         rstv  [7] = '{8'h11, 8'h01, 8'h00, 8'h00, 8'h00, 8'h30, 8'h30};
    logic [7:0]         masks [7] = '{8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    audio_source src (.mclk_in(mclk_in), .clk_mode_in(clk_mode), .bclk_out(bclk), .fclk_out(fclk),
                      .valid_out(svalid), .sample_out(sample));

    audio_path_automute_config #(.MISS_UNIT_CYCLES(UNIT)) DUT (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .bclk_in(bclk), .fclk_in(fclk), .ignore_missing_clock_in(ignore), .sample_valid_in(svalid),
        .sample_in(sample), .dac_out(dac), .dac_valid_out(dvalid), .left_muted_out(lmute),
        .right_muted_out(rmute), .clock_missing_out(miss), .dac_powerdown_out(pdown),
        .program_out(prog), .program_rom1_out(rom1), .left_volume_out(lvol), .right_volume_out(rvol));

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk_in);
        req.wr = 1'b0;
    endtask

    // read data is registered on the edge that takes rd, so it is sampled at the next falling edge
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_in);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
        @(negedge mclk_in);
        req.rd = 1'b0;
        check("reg_rdata", exp, rdata);
    endtask

    function automatic logic [23:0] pick(input logic [1:0] c, input logic [23:0] own, input logic [23:0] oth);
        return (c == 2'h1) ? own : ((c == 2'h2) ? oth : 24'h000000);
    endfunction

    // zero-run length in samples at the 96 kHz reference rate
    function automatic int am_len(input int c);
        int us [8] = '{11500, 53000, 106500, 266500, 535000, 1065000, 2665000, 5330000};
        return us[c] * 96 / 1000;
    endfunction

    initial begin
        #(40000 * 10);
        bad_count++;
        print_verdict();
    end

    initial begin
        logic [7:0]  d;
        logic [7:0]  v1;
        logic [23:0] l;
        logic [23:0] r;
        int          nl;
        int          nr;
        int          t;
        bad_count = 0;
        checks_done = 0;
        req = '0;
        ignore = 1'b0;
        clk_mode = 2'h0;
        arst_n_in = 1'b0;
        void'($urandom(32'h5DE22849));
        repeat (10) @(posedge mclk_in);
        @(negedge mclk_in);
        arst_n_in = 1'b1;
        repeat (3) @(negedge mclk_in);

        for (int i = 0; i < 7; i++) reg_chk(addrs[i], rstv[i]);
        check("program", 6'h21, {rom1, prog});
        check("volumes", 16'h3030, {lvol, rvol});
        for (int i = 0; i < 7; i++) begin
            d = 8'($urandom);
            reg_wr(addrs[i], d);
            reg_chk(addrs[i], d & masks[i]);
        end
        reg_wr(8'h50, 8'hA5);
        reg_chk(8'h50, 8'h00);
        // random volume and link codes may hold the mute code, so put them back
        reg_wr(8'h3C, 8'h00);
        reg_wr(8'h3D, 8'h30);
        reg_wr(8'h3E, 8'h30);
        $display("test registers done");

        for (int i = 0; i < 16; i++) begin
            reg_wr(8'h2A, {2'h0, i[3:2], 2'h0, i[1:0]});
            l = 24'($urandom) | 24'h000001;
            r = 24'($urandom) | 24'h000002;
            src.stream(l, r, 1);
            check("dac_out", {pick(i[3:2], l, r), pick(i[1:0], r, l)}, dac);
            check("dac_valid", 1'b1, dvalid);
        end
        $display("test routing done");

        for (int c = 0; c < 4; c++) begin
            reg_wr(8'h2B, 8'hE0 | 8'(c));
            check("rom1", (c == 1), rom1);
            check("program", c, prog);
        end
        $display("test program done");

        reg_wr(8'h2A, 8'h11);
        v1 = {1'b0, 7'($urandom)};
        // bit 0 kept low so the right code can never be the mute code
        d = {1'b1, 6'($urandom), 1'b0};
        reg_wr(8'h3D, v1);
        reg_wr(8'h3E, d);
        for (int c = 0; c < 4; c++) begin
            reg_wr(8'h3C, 8'(c));
            check("right_volume", (c == 1) ? v1 : d, rvol);
            check("left_volume", v1, lvol);
        end
        reg_wr(8'h3D, 8'hFF);
        src.stream(24'h123456, 24'h654321, 1);
        check("dac_out", {24'h000000, 24'h654321}, dac);
        reg_wr(8'h3D, 8'h30);
        $display("test volume done");

        reg_wr(8'h2C, 8'h01);
        t = 1 + 2 * UNIT;
        clk_mode <= 2'h1;
        repeat (t - 10) @(negedge mclk_in);
        check("clock_missing", 1'b0, miss);
        repeat (20) @(negedge mclk_in);
        check("clock_missing", 1'b1, miss);
        check("powerdown", 1'b1, pdown);
        src.stream(24'h00000F, 24'h0000F0, 1);
        check("dac_out", 48'h0, dac);
        ignore = 1'b1;
        repeat (2) @(negedge mclk_in);
        check("powerdown", 1'b0, pdown);
        ignore = 1'b0;
        clk_mode <= 2'h0;
        repeat (3) @(negedge mclk_in);
        check("clock_missing", 1'b0, miss);
        clk_mode <= 2'h2;
        repeat (t + 20) @(negedge mclk_in);
        check("clock_missing", 1'b0, miss);
        clk_mode <= 2'h0;
        $display("test clock loss done");

        reg_wr(8'h3B, 8'h01);
        nl = am_len(0);
        nr = am_len(1);
        src.stream(24'h000000, 24'h000001, nl - 1);
        check("left_muted", 1'b0, lmute);
        src.stream(24'h000000, 24'h000001, 1);
        @(negedge mclk_in);
        check("left_muted", 1'b1, lmute);
        check("right_muted", 1'b0, rmute);
        src.stream(24'h000005, 24'h000001, 1);
        @(negedge mclk_in);
        check("left_muted", 1'b0, lmute);
        src.stream(24'h000001, 24'h000000, nr - 1);
        src.stream(24'h000001, 24'h000007, 1);
        src.stream(24'h000001, 24'h000000, nr - 1);
        check("right_muted", 1'b0, rmute);
        src.stream(24'h000001, 24'h000000, 1);
        @(negedge mclk_in);
        check("right_muted", 1'b1, rmute);
        check("left_muted", 1'b0, lmute);
        $display("test auto mute done");
        print_verdict();
    end
endmodule
